// >>> freq_limit_consts.vh
// Constants for the frequency limit and stall selection block
`ifndef FREQ_LIMIT_CONSTS_VH
`define FREQ_LIMIT_CONSTS_VH
// Frequencies in units of 0.01 Hz, 16 bits
`define FREQ_W 16
`define FREQ_0HZ 16'h0000
`define FREQ_120HZ 16'h2EE0
`define FREQ_400HZ 16'h9C40
`define SEL_W 8
`define SEL_RESET 8'h00
`define SEL_DRIVE_ONLY 8'h64
`define SEL_DRIVE_NOFAST 8'h65
`define SEL_BIT_MAX 8'h1F
`define SEL_FAST_OFF 0
`define SEL_ACC_OFF 1
`define SEL_CONST_OFF 2
`define SEL_DEC_OFF 3
`define SEL_WARN_STOP 4
`define PHASE_ACC 2'h0
`define PHASE_CONST 2'h1
`define PHASE_DEC 2'h2
`define PHASE_NONE 2'h3
`define USER_GRP_OPEN 8'h00
`endif

// >>> freq_clamp.v
// Combinational clamp of a frequency command between two limits
`timescale 1ns/1ps
`default_nettype none
module freq_clamp #(
   parameter W = 16
) (
   // Command and limits
   input wire [W-1:0] cmd_i,
   input wire [W-1:0] lo_i,
   input wire [W-1:0] hi_i,
   // Limited result
   output wire [W-1:0] out_o
);
   // Upper clamp is tested first; if limits cross, a command below both gets the minimum, which exceeds the maximum
   assign out_o = (cmd_i > hi_i) ? hi_i :
                  (cmd_i < lo_i) ? lo_i : cmd_i;
endmodule
`default_nettype wire

// >>> freq_limit_stall_select.v
// Frequency limits and stall prevention selection decoder
`timescale 1ns/1ps
`default_nettype none
`include "freq_limit_consts.vh"
module freq_limit_stall_select #(
   parameter W = `FREQ_W
) (
   // Clock, reset, enable
   input wire clk_i,
   input wire rst_b_i,
   input wire ce_i,
   // Setting writes
   input wire max_wr_i,
   input wire min_wr_i,
   input wire hs_wr_i,
   input wire sel_wr_i,
   input wire [W-1:0] wr_freq_i,
   input wire [`SEL_W-1:0] wr_sel_i,
   input wire [`SEL_W-1:0] user_group_read_sel_i,
   // Operating state
   input wire [W-1:0] freq_cmd_i,
   input wire [1:0] phase_i,
   input wire regen_i,
   input wire stall_active_i,
   input wire fast_active_i,
   input wire fault_clear_i,
   // Settings readback
   output reg [W-1:0] max_freq_setting_o,
   output reg [W-1:0] min_freq_setting_o,
   output reg [W-1:0] high_speed_max_setting_o,
   output reg [`SEL_W-1:0] stall_limit_select_o,
   output reg wr_reject_o,
   // Drive side
   output reg [W-1:0] freq_out_o,
   output reg stall_en_o,
   output reg fast_limit_en_o,
   output reg overload_warn_o,
   output reg stall_stop_fault_o,
   output reg run_stop_o
);
   // Clamp and limit selection
   reg [W-1:0] lim_nxt;
   wire [W-1:0] clamped;
   // Selection decode
   wire [2:0] phase_allow;
   reg sel_table;
   reg sel_drive;
   reg stall_nxt;
   reg fast_nxt;
   reg warn_stop;
   reg all_off;
   // Warning and fault
   reg warn_nxt;
   reg fault_nxt;
   // Setting writes
   reg max_ok;
   reg min_ok;
   reg hs_ok;
   reg [W-1:0] max_nxt;
   reg [W-1:0] min_nxt;
   reg [W-1:0] hs_nxt;
   reg [`SEL_W-1:0] sel_nxt;
   reg rej_nxt;

   // True when a written frequency lies inside a closed range
   function in_band;
      input [W-1:0] val;
      input [W-1:0] lo;
      input [W-1:0] hi;
      begin
         in_band = (val >= lo) && (val <= hi);
      end
   endfunction

   // True for the selection codes that the table defines bit by bit
   function in_table;
      input [`SEL_W-1:0] sel;
      begin
         in_table = (sel <= `SEL_BIT_MAX);
      end
   endfunction

   // True for the two codes that split driving from regeneration
   function is_drive_code;
      input [`SEL_W-1:0] sel;
      begin
         is_drive_code = (sel == `SEL_DRIVE_ONLY) ||
                         (sel == `SEL_DRIVE_NOFAST);
      end
   endfunction

   // One stall permission bit per phase, taken from bits 1 to 3
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_phase
         assign phase_allow[g] =
            ~stall_limit_select_o[`SEL_ACC_OFF + g];
      end
   endgenerate

   // Codes outside the table, other than the two drive codes, behave as the power-on setting
   always @* begin
      sel_table = in_table(stall_limit_select_o);
      sel_drive = is_drive_code(stall_limit_select_o);
      stall_nxt = 1'b0;
      fast_nxt = 1'b1;
      warn_stop = 1'b0;
      all_off = 1'b0;
      if (sel_table) begin
         fast_nxt = ~stall_limit_select_o[`SEL_FAST_OFF];
         warn_stop = stall_limit_select_o[`SEL_WARN_STOP];
         all_off = ~|phase_allow;
         case (phase_i)
            `PHASE_ACC: stall_nxt = phase_allow[0];
            `PHASE_CONST: stall_nxt = phase_allow[1];
            `PHASE_DEC: stall_nxt = phase_allow[2];
            default: stall_nxt = 1'b0;
         endcase
      end else if (sel_drive) begin
         // Regeneration switches every limit off
         stall_nxt = ~regen_i && phase_i != `PHASE_NONE;
         fast_nxt = ~regen_i &&
                    stall_limit_select_o == `SEL_DRIVE_ONLY;
         all_off = regen_i;
      end else begin
         case (phase_i)
            `PHASE_NONE: stall_nxt = 1'b0;
            default: stall_nxt = 1'b1;
         endcase
      end
   end

   // Warning follows stall action only; fast limiting never counts
   always @* begin
      warn_nxt = stall_active_i & stall_nxt & ~all_off;
      fault_nxt = stall_stop_fault_o;
      if (fault_clear_i)
         fault_nxt = 1'b0;
      // A warning in the clearing cycle sets the fault again
      if (warn_nxt & warn_stop)
         fault_nxt = 1'b1;
   end

   // Range and lock checks of the written value
   always @* begin
      max_ok = in_band(wr_freq_i, `FREQ_0HZ, `FREQ_120HZ);
      min_ok = in_band(wr_freq_i, `FREQ_0HZ, `FREQ_120HZ);
      hs_ok = in_band(wr_freq_i, `FREQ_120HZ, `FREQ_400HZ) &&
              user_group_read_sel_i == `USER_GRP_OPEN;
   end

   // Both maxima move together; a high-speed write wins a same-cycle tie
   always @* begin
      max_nxt = max_freq_setting_o;
      min_nxt = min_freq_setting_o;
      hs_nxt = high_speed_max_setting_o;
      sel_nxt = stall_limit_select_o;
      rej_nxt = 1'b0;
      if (max_wr_i) begin
         if (max_ok) begin
            max_nxt = wr_freq_i;
            hs_nxt = wr_freq_i;
         end else begin
            rej_nxt = 1'b1;
         end
      end
      if (min_wr_i) begin
         if (min_ok) begin
            min_nxt = wr_freq_i;
         end else begin
            rej_nxt = 1'b1;
         end
      end
      if (hs_wr_i) begin
         if (hs_ok) begin
            hs_nxt = wr_freq_i;
            max_nxt = wr_freq_i;
         end else begin
            rej_nxt = 1'b1;
         end
      end
      if (sel_wr_i)
         sel_nxt = wr_sel_i;
   end

   // Maximum in force is the high-speed one once above 120 Hz
   always @* begin
      lim_nxt = max_freq_setting_o;
      if (high_speed_max_setting_o > `FREQ_120HZ)
         lim_nxt = high_speed_max_setting_o;
   end

   // Clamp sits before the output register, so it sees each new command
   freq_clamp #(
      .W(W)
   ) i_freq_clamp (
      .cmd_i(freq_cmd_i),
      .lo_i(min_freq_setting_o),
      .hi_i(lim_nxt),
      .out_o(clamped)
   );

   // Maximum frequency; a low enable freezes it like all other state
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         max_freq_setting_o <= `FREQ_120HZ;
      end else if (ce_i) begin
         max_freq_setting_o <= max_nxt;
      end
   end

   // Minimum frequency
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         min_freq_setting_o <= `FREQ_0HZ;
      end else if (ce_i) begin
         min_freq_setting_o <= min_nxt;
      end
   end

   // High-speed maximum
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         high_speed_max_setting_o <= `FREQ_120HZ;
      end else if (ce_i) begin
         high_speed_max_setting_o <= hs_nxt;
      end
   end

   // Stall selection code
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stall_limit_select_o <= `SEL_RESET;
      end else if (ce_i) begin
         stall_limit_select_o <= sel_nxt;
      end
   end

   // Reject pulse stands for one enabled cycle after a refused write
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_reject_o <= 1'b0;
      end else if (ce_i) begin
         wr_reject_o <= rej_nxt;
      end
   end

   // Registered copy of the clamp: one cycle behind the command
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         freq_out_o <= `FREQ_0HZ;
      end else if (ce_i) begin
         freq_out_o <= clamped;
      end
   end

   // Stall prevention enable towards the drive stage
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stall_en_o <= 1'b0;
      end else if (ce_i) begin
         stall_en_o <= stall_nxt;
      end
   end

   // Fast-response limiting enable towards the drive stage
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fast_limit_en_o <= 1'b0;
      end else if (ce_i) begin
         fast_limit_en_o <= fast_nxt;
      end
   end

   // Overload warning
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         overload_warn_o <= 1'b0;
      end else if (ce_i) begin
         overload_warn_o <= warn_nxt;
      end
   end

   // Stall stop fault stands until cleared
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stall_stop_fault_o <= 1'b0;
      end else if (ce_i) begin
         stall_stop_fault_o <= fault_nxt;
      end
   end

   // Stop request follows the fault so the drive halts with it
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run_stop_o <= 1'b0;
      end else if (ce_i) begin
         run_stop_o <= fault_nxt;
      end
   end
endmodule
`default_nettype wire

// >>> fls_monitor.sv
// Checker on the ports of the frequency limit block
`timescale 1ns/1ps
`default_nettype none
module fls_monitor (
   input wire logic clk_i, rst_b_i, ce_i, max_wr_i, min_wr_i, hs_wr_i,
   input wire logic sel_wr_i, stall_active_i, overload_warn_o,
   input wire logic stall_stop_fault_o, run_stop_o,
   input wire logic [1:0] phase_i,
   input wire logic [7:0] user_group_read_sel_i, stall_limit_select_o,
   input wire logic [15:0] wr_freq_i, freq_cmd_i, freq_out_o,
   input wire logic [15:0] max_freq_setting_o, min_freq_setting_o,
   input wire logic [15:0] high_speed_max_setting_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // Limits only move on writes, so quiet cycles give exact clamp values
   wire q = ce_i && !max_wr_i && !min_wr_i && !hs_wr_i;
   wire ok = min_freq_setting_o <= max_freq_setting_o;
   limits_tied_a:
      assert property (max_freq_setting_o == high_speed_max_setting_o)
      else $error("limits differ");
   hs_write_a:
      assert property (ce_i && hs_wr_i && user_group_read_sel_i == 8'h00
      && wr_freq_i >= 16'h2EE0 && wr_freq_i <= 16'h9C40
      |=> max_freq_setting_o == $past(wr_freq_i)) else $error("hs write");
   hs_lock_a:
      assert property (ce_i && hs_wr_i && !max_wr_i &&
      user_group_read_sel_i != 8'h00 |=> $stable(high_speed_max_setting_o))
      else $error("locked hs write");
   top_clamp_a:
      assert property (q && ok && freq_cmd_i > max_freq_setting_o |=>
      freq_out_o == $past(max_freq_setting_o)) else $error("top clamp");
   low_clamp_a:
      assert property (q && ok && freq_cmd_i < min_freq_setting_o |=>
      freq_out_o == $past(min_freq_setting_o)) else $error("low clamp");
   fast_quiet_a:
      assert property (ce_i && !stall_active_i |=> !overload_warn_o)
      else $error("warn without stall");
   no_stall_a:
      assert property (ce_i && !sel_wr_i && stall_limit_select_o[3:1] ==
      3'h7 && stall_limit_select_o < 8'h20 |=> !overload_warn_o)
      else $error("warn while stall off");
   stop_fault_a:
      assert property (ce_i && !sel_wr_i && stall_active_i && phase_i == 2'h0
      && stall_limit_select_o == 8'h10 |-> ##[1:2] stall_stop_fault_o &&
      run_stop_o) else $error("no stop fault");
   cover property (ce_i && hs_wr_i);
   cover property ($rose(stall_stop_fault_o));
   cover property (overload_warn_o);
   cover property (stall_limit_select_o == 8'h64 && overload_warn_o);
endmodule
bind freq_limit_stall_select fls_monitor i_fls_monitor (.*);
`default_nettype wire

// >>> cmd_source.sv
// Frequency command source feeding the limit block
`timescale 1ns/1ps
`default_nettype none
module cmd_source (
   input wire logic clk_i, rst_b_i,
   input wire logic [15:0] set_i,
   output logic [15:0] freq_cmd_o
);
   // A source updates its command on the clock; only the reset clears it mid-cycle
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) freq_cmd_o <= 16'h0000;
      else freq_cmd_o <= set_i;
   end
endmodule
`default_nettype wire

// >>> freq_limit_stall_select_tb_top.sv
// Bench for the frequency limit and stall selection block
`timescale 1ns/1ps
`default_nettype none
module freq_limit_stall_select_tb_top;
   logic clk_i = 0, rst_b_i = 0, rg = 0, st = 0, fa = 0, fc = 0, ce = 1;
   logic rej, se, fe, ow, sf, rs;
   logic [3:0] ws = 0;
   logic [1:0] ph = 0;
   logic [7:0] ug = 0, sd = 0, sel;
   logic [15:0] wd = 0, set = 0, cmd, fo, mx, mn, hs;
   logic [7:0] tv [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h1F,
      8'h64, 8'h65};
   int num_errors = 0, num_checks = 0;
   initial forever #5 clk_i = ~clk_i;
   cmd_source i_cmd_source (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .set_i(set), .freq_cmd_o(cmd));
   freq_limit_stall_select i_freq_limit_stall_select (.clk_i(clk_i),
      .rst_b_i(rst_b_i), .ce_i(ce), .max_wr_i(ws[0]), .min_wr_i(ws[1]),
      .hs_wr_i(ws[2]), .sel_wr_i(ws[3]), .wr_freq_i(wd), .wr_sel_i(sd),
      .user_group_read_sel_i(ug), .freq_cmd_i(cmd), .phase_i(ph),
      .regen_i(rg), .stall_active_i(st), .fast_active_i(fa),
      .fault_clear_i(fc), .max_freq_setting_o(mx), .min_freq_setting_o(mn),
      .high_speed_max_setting_o(hs), .stall_limit_select_o(sel),
      .wr_reject_o(rej), .freq_out_o(fo), .stall_en_o(se),
      .fast_limit_en_o(fe), .overload_warn_o(ow),
      .stall_stop_fault_o(sf), .run_stop_o(rs));
   task automatic go(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] s, input logic [15:0] d);
      @(posedge clk_i) begin ws <= s; wd <= d; sd <= d[7:0]; end
      @(posedge clk_i) ws <= 4'h0;
      #1;
   endtask
   task automatic sc(input logic [15:0] v, input logic [15:0] e);
      @(posedge clk_i) set <= v;
      go(3);
      chk(fo, e);
   endtask
   // Expected {stall enable, fast enable}; regen only matters above 31
   function automatic logic [1:0] ex(input logic [7:0] s, input int k);
      if (s > 8'h1F) return {k < 3, s == 8'h64 && k < 3};
      return {!s[k % 3 + 1], !s[0]};
   endfunction
   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #50000;
      num_errors++;
      finish_test;
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1;
      go(1);
      chk(mx, 16'h2EE0);
      chk(mn, 16'h0000);
      chk(hs, 16'h2EE0);
      sc(16'h3A98, 16'h2EE0);
      wr(4'h1, 16'h2EE1);
      chk({rej, mx[14:0]}, 16'hAEE0);
      wr(4'h4, 16'h4E20);
      chk(mx, 16'h4E20);
      sc(16'h3A98, 16'h3A98);
      @(posedge clk_i) ug <= 8'h01;
      wr(4'h4, 16'h9C40);
      chk({rej, hs[14:0]}, 16'hCE20);
      @(posedge clk_i) ug <= 8'h00;
      wr(4'h4, 16'h9C41);
      chk(rej, 1'b1);
      wr(4'h1, 16'h1F40);
      chk(hs, 16'h1F40);
      wr(4'h2, 16'h0FA0);
      sc(16'h03E8, 16'h0FA0);
      sc(16'h1388, 16'h1388);
      chk(mn, 16'h0FA0);
      wr(4'h2, 16'h2EE1);
      chk({rej, mn[14:0]}, 16'h8FA0);
      // A write while the enable is low must not land
      @(posedge clk_i) ce <= 0;
      wr(4'h1, 16'h1000);
      chk(mx, 16'h1F40);
      @(posedge clk_i) ce <= 1;
      foreach (tv[i]) begin
         wr(4'h8, {8'h00, tv[i]});
         for (int k = 0; k < 6; k++) begin
            @(posedge clk_i) begin ph <= 2'(k % 3); rg <= k > 2; end
            go(2);
            chk({se, fe}, ex(tv[i], k));
         end
      end
      wr(4'h8, 16'h0000);
      @(posedge clk_i) begin ph <= 2'h0; rg <= 0; fa <= 1; end
      go(2);
      chk(ow, 1'b0);
      @(posedge clk_i) st <= 1;
      go(2);
      chk({ow, sf}, 2'b10);
      wr(4'h8, 16'h000E);
      go(1);
      chk(ow, 1'b0);
      wr(4'h8, 16'h0010);
      go(2);
      chk({sf, rs}, 2'b11);
      @(posedge clk_i) begin st <= 0; fc <= 1; end
      go(2);
      chk(sf, 1'b0);
      wr(4'h8, 16'h001E);
      @(posedge clk_i) begin st <= 1; fc <= 0; end
      go(2);
      chk({ow, sf, rs}, 3'b000);
      wr(4'h8, 16'h0064);
      @(posedge clk_i) rg <= 1;
      go(2);
      chk(ow, 1'b0);
      @(posedge clk_i) rg <= 0;
      go(2);
      chk(ow, 1'b1);
      finish_test;
   end
endmodule
`default_nettype wire
